// >>> bench/sadc_analog.sv
// Purpose: Input mux and comparator facing the sequencer
// Assumes: Ideal comparator; bias only trims accuracy, so it is ignored
// Notes:   Levels come from the bench, eight bits per channel
`timescale 1ns/1ps
`default_nettype none
module sadc_analog (
   input  wire logic [63:0] levels,
   input  wire logic [2:0]  channel_sel,
   input  wire logic [7:0]  dac_code,
   output logic             cmp_high
);
   assign cmp_high = levels[channel_sel*8 +: 8] >= dac_code;
endmodule
`default_nettype wire

// >>> bench/sadc_seq_properties.sv
// Purpose: Port checks of the sequencer
// Assumes: Freeze inputs act on the edge at which they are seen
// Notes:   Bound to sadc_seq below
`timescale 1ns/1ps
`default_nettype none
module sadc_seq_properties (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [11:0] addr,
   input wire logic        wr_byte,
   input wire logic [7:0]  wdata,
   input wire logic        rd,
   input wire logic        stop_mode,
   input wire logic        halt_mode,
   input wire logic        system_clock_select,
   input wire logic [7:0]  rdata,
   input wire logic [2:0]  channel_sel,
   input wire logic        bias_select_bit,
   input wire logic        sample_hold,
   input wire logic        busy
);
   import sadc_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic mw;
   logic frz;
   assign mw = wr_byte && addr == MODE_ADDR;
   assign frz = stop_mode | halt_mode | system_clock_select;
   chk_chan_load: assert property (mw |->
      ##2 channel_sel == $past(wdata[6:4], 2)) else $error("bad channel");
   chk_bias_load: assert property (mw |->
      ##2 bias_select_bit == $past(wdata[1], 2)) else $error("bad bias");
   chk_conv_len: assert property (disable iff (!rst_b || frz)
      $rose(busy) |-> ##[176:192] !busy) else $error("bad conversion time");
   chk_start_dly: assert property ($rose(busy) |->
      ##[1:17] $rose(sample_hold)) else $error("late sampling");
   chk_sample_win: assert property ($rose(sample_hold) |->
      sample_hold[*8] ##1 !sample_hold) else $error("bad sample window");
   chk_sample_busy: assert property (sample_hold |-> busy)
      else $error("sampling while idle");
   // busy and sample_hold lag the state by one clock, so the freeze
   // must already have stood for two edges before they stop moving
   chk_freeze_hold: assert property (frz && $past(frz) && $past(frz, 2) |->
      $stable(busy) && $stable(sample_hold)) else $error("ran while frozen");
   chk_rdata_hold: assert property (!$past(rd) && !$past(rd, 2) |->
      $stable(rdata)) else $error("read data moved");
   cover property ($fell(busy));
   cover property (frz && busy);
   cover property (mw && wdata[3]);
endmodule
bind sadc_seq sadc_seq_properties u_chk (.mclk, .rst_b, .addr, .wr_byte,
   .wdata, .rd, .stop_mode, .halt_mode, .system_clock_select, .rdata,
   .channel_sel, .bias_select_bit, .sample_hold, .busy);
`default_nettype wire

// >>> bench/test_sar_adc_sequencer.sv
// Purpose: Self-checking bench of the sequencer
// Assumes: Ideal comparator model
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_sar_adc_sequencer;
   import sadc_pkg::*;
   logic mclk = 0, rst_b = 0, wr_byte = 0, wr_bit = 0, bit_val = 0, rd = 0;
   logic stop_mode = 0, halt_mode = 0, system_clock_select = 0;
   logic [11:0] addr = 0;
   logic [7:0]  wdata = 0, rdata, dac_code, got;
   logic [2:0]  bit_sel = 0, channel_sel;
   logic [63:0] levels = 0;
   logic        cmp_high, bias_select_bit, sample_hold, busy;
   int          err_count = 0, cmp_count = 0;
   always #25 mclk = ~mclk;
   sadc_seq u_dut (.mclk, .rst_b, .addr, .wr_byte, .wr_bit, .bit_sel,
      .bit_val, .wdata, .rd, .stop_mode, .halt_mode, .system_clock_select,
      .cmp_high, .rdata, .channel_sel, .bias_select_bit, .sample_hold,
      .dac_code, .busy);
   sadc_analog u_ana (.levels, .channel_sel, .dac_code, .cmp_high);
   function automatic logic [7:0] mexp(input logic [7:0] m, input logic d);
      return {1'b0, m[6:4], 1'b0, d, m[1], 1'b0};
   endfunction
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_byte = 1;
      @(negedge mclk) wr_byte = 0;
   endtask
   task automatic wb(input logic [2:0] s, input logic v);
      addr = MODE_ADDR;
      bit_sel = s;
      bit_val = v;
      wr_bit = 1;
      @(negedge mclk) wr_bit = 0;
   endtask
   task automatic rdr(input logic [11:0] a);
      addr = a;
      rd = 1;
      @(negedge mclk) rd = 0;
      @(negedge mclk) got = rdata;
   endtask
   task automatic conv(input logic [7:0] m, input logic bw, input logic [1:0] f);
      logic [7:0] lv;
      lv = levels[m[6:4]*8 +: 8];
      if (bw) begin
         wr(MODE_ADDR, m & 8'hf7);
         wb(6, ~m[6]);
         wb(3, 1);
      end else wr(MODE_ADDR, m);
      // Past the start delay and the sample window before any freeze
      repeat (40) @(negedge mclk);
      rdr(MODE_ADDR);
      `CHK("mode run", mexp(m, 0), got)
      `CHK("channel", m[6:4], channel_sel)
      `CHK("bias", m[1], bias_select_bit)
      stop_mode = f[0];
      halt_mode = f[1];
      if (f != 0) begin
         repeat (200) @(negedge mclk);
         `CHK("frozen busy", 1'b1, busy)
      end
      stop_mode = 0;
      halt_mode = 0;
      for (int i = 0; i < 300 && busy !== 0; i++) @(negedge mclk);
      rdr(MODE_ADDR);
      `CHK("mode done", mexp(m, 1), got)
      wr(RESULT_ADDR, ~lv);
      rdr(RESULT_ADDR);
      `CHK("result", lv, got)
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h4afe3531));
      // Levels never move during a run; the shared port is never read
      levels = {$urandom, $urandom};
      levels[31:24] = 8'hff;
      levels[39:32] = 8'h00;
      repeat (3) @(negedge mclk);
      rst_b = 1;
      rdr(MODE_ADDR);
      `CHK("mode reset", MODE_RESET, got)
      wr(12'hfd9, 8'hff);
      rdr(MODE_ADDR);
      `CHK("unmapped", MODE_RESET, got)
      conv(8'hbb, 0, 0);
      conv(8'h48, 1, 1);
      conv(8'h18, 0, 2);
      for (int k = 0; k < 6; k++) conv(8'h08 | 8'($urandom) & 8'hf3, k[0], 0);
      // Subsystem clock selected: a start must not run until it is deselected
      system_clock_select = 1;
      wr(MODE_ADDR, 8'h08);
      repeat (250) @(negedge mclk);
      `CHK("scc busy", 1'b0, busy)
      system_clock_select = 0;
      repeat (400) @(negedge mclk);
      give_verdict;
   end
   initial begin
      #2000000;
      err_count++;
      give_verdict;
   end
endmodule
`default_nettype wire

// >>> core/sadc_pkg.sv
// Purpose: Shared constants for the converter sequencer
// Assumes: One main clock, synchronous active-low reset
// Notes:   Times are in main-clock periods
package sadc_pkg;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned ADDR_W       = 12;
   localparam logic [11:0] RESULT_ADDR  = 12'hfda;
   localparam logic [11:0] MODE_ADDR    = 12'hfd8;
   localparam logic [7:0]  MODE_RESET   = 8'h04;
   localparam int unsigned CH_LO        = 4;
   localparam int unsigned CH_HI        = 6;
   localparam int unsigned DONE_BIT     = 2;
   localparam int unsigned START_BIT    = 3;
   localparam int unsigned BIAS_BIT     = 1;
   localparam int unsigned CH_W         = 3;
   localparam int unsigned START_DLY    = 16;
   localparam int unsigned CONV_CYC     = 168;
   localparam int unsigned SAMPLE_CYC   = 8;
   localparam int unsigned STEP_CYC     = 20;
   localparam int unsigned CNT_W        = 8;
   typedef enum logic [1:0] {
      SADC_IDLE,
      SADC_WAIT,
      SADC_SAMPLE,
      SADC_CONV
   } sadc_state_e;
endpackage

// >>> core/sadc_sar.sv
// Purpose: Successive-approximation bit trial register
// Assumes: Comparator output is settled when step is pulsed
// Notes:   MSB first; one decided bit per step pulse
`timescale 1ns/1ps
`default_nettype none
module sadc_sar #(
   parameter int unsigned WIDTH = sadc_pkg::DATA_W
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic             clear,
   input  wire logic             step,
   input  wire logic             cmp_high,
   output logic [WIDTH-1:0]      trial,
   output logic                  last
);
   logic [WIDTH-1:0] mask;
   assign last = mask[0];
   always_ff @(posedge mclk) begin
      if (!rst_b || clear) begin
         mask  <= {1'b1, {(WIDTH-1){1'b0}}};
         trial <= {1'b1, {(WIDTH-1){1'b0}}};
      end else if (step) begin
         // Keep the tried bit only when input is at or above the trial level
         trial <= (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
         mask  <= mask >> 1;
      end
   end
endmodule
`default_nettype wire

// >>> core/sadc_seq.sv
// Purpose: Mode register, start delay, sample and convert sequencing
// Assumes: Register access on a simple data-memory strobe interface
// Notes:   Result output is registered; no bus other than data memory
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Bits 6 to 4 of the mode register pick one of eight analog channels.
// - Bit 1 of the mode register drives the comparator bias select.
// - Reset loads the mode register with 04h, only the done flag set.
// - The mode register is written whole, and bits 2 and 3 also singly.
// - Writing one to the start bit launches a conversion and it self-clears.
// - Within sixteen main clocks of start the done flag clears and work begins.
// - Sampling and conversion take 168 clocks, then result loads and done sets.
// - The result holds old data through the start delay, is undefined while sampling or converting, then new.
// - The result register is read only and ignores writes.
// - The result sits at address fdah and is undefined after reset.
// - The converter runs on the main clock and stops in stop or halt mode.
module sadc_seq
   import sadc_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic [sadc_pkg::ADDR_W-1:0] addr,
   input  wire logic                    wr_byte,
   input  wire logic                    wr_bit,
   input  wire logic [2:0]              bit_sel,
   input  wire logic                    bit_val,
   input  wire logic [sadc_pkg::DATA_W-1:0] wdata,
   input  wire logic                    rd,
   input  wire logic                    stop_mode,
   input  wire logic                    halt_mode,
   input  wire logic                    system_clock_select,
   input  wire logic                    cmp_high,
   output logic [sadc_pkg::DATA_W-1:0]  rdata,
   output logic [sadc_pkg::CH_W-1:0]    channel_sel,
   output logic                         bias_select_bit,
   output logic                         sample_hold,
   output logic [sadc_pkg::DATA_W-1:0]  dac_code,
   output logic                         busy
);
   import sadc_pkg::*;

   localparam logic [CNT_W-1:0] DLY_END  = CNT_W'(START_DLY - 1);
   localparam logic [CNT_W-1:0] SMP_END  = CNT_W'(SAMPLE_CYC - 1);
   localparam logic [CNT_W-1:0] STEP_END = CNT_W'(STEP_CYC - 1);

   sadc_state_e            state;
   logic [DATA_W-1:0]      conversion_mode_register;
   logic [DATA_W-1:0]      approximation_result_register;
   logic [CNT_W-1:0]       cnt;
   logic                   run_ok;
   logic                   hit_mode;
   logic                   start_req;
   logic                   sar_clear;
   logic                   sar_step;
   logic                   sar_last;
   logic [DATA_W-1:0]      sar_trial;
   logic                   finish;

   function automatic logic [DATA_W-1:0] set_bit(
      input logic [DATA_W-1:0] v,
      input logic [2:0]        idx,
      input logic              val
   );
      logic [DATA_W-1:0] r;
      r = v;
      r[idx] = val;
      return r;
   endfunction

   // Subsystem clock or stop/halt freezes the sequence in place
   assign run_ok   = !stop_mode && !halt_mode && !system_clock_select;
   assign hit_mode = (addr == MODE_ADDR);
   assign start_req = conversion_mode_register[START_BIT];
   assign sar_step = (state == SADC_CONV) && run_ok && (cnt == STEP_END);
   assign sar_clear = (state == SADC_SAMPLE);
   assign finish   = sar_step && sar_last;

   sadc_sar #(
      .WIDTH    (DATA_W)
   ) u_sar (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .clear    (sar_clear),
      .step     (sar_step),
      .cmp_high (cmp_high),
      .trial    (sar_trial),
      .last     (sar_last)
   );

   // Mode register; hardware done/start updates win over software writes
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         conversion_mode_register <= MODE_RESET;
      end else begin
         logic [DATA_W-1:0] nv;
         nv = conversion_mode_register;
         if (hit_mode && wr_byte)
            nv = wdata;
         else if (hit_mode && wr_bit &&
                  (bit_sel == 3'(DONE_BIT) || bit_sel == 3'(START_BIT)))
            nv = set_bit(nv, bit_sel, bit_val);
         nv[0] = 1'b0;
         nv[7] = 1'b0;
         if (state == SADC_IDLE && start_req && run_ok)
            nv[START_BIT] = 1'b0;
         if (state == SADC_WAIT && run_ok && cnt == DLY_END)
            nv[DONE_BIT] = 1'b0;
         if (finish)
            nv[DONE_BIT] = 1'b1;
         conversion_mode_register <= nv;
      end
   end

   // Sequencer: start delay, sample window, eight bit trials
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= SADC_IDLE;
         cnt   <= '0;
      end else if (run_ok) begin
         unique case (state)
            SADC_IDLE: begin
               cnt <= '0;
               if (start_req)
                  state <= SADC_WAIT;
            end
            SADC_WAIT: begin
               cnt <= cnt + 1'b1;
               if (cnt == DLY_END) begin
                  state <= SADC_SAMPLE;
                  cnt   <= '0;
               end
            end
            SADC_SAMPLE: begin
               cnt <= cnt + 1'b1;
               if (cnt == SMP_END) begin
                  state <= SADC_CONV;
                  cnt   <= '0;
               end
            end
            SADC_CONV: begin
               // 8 sample + 8 x 20 trial clocks = 168
               cnt <= (cnt == STEP_END) ? '0 : cnt + 1'b1;
               if (finish)
                  state <= SADC_IDLE;
            end
         endcase
      end
   end

   // Result is written only by the converter; no reset value
   always_ff @(posedge mclk) begin
      if (finish)
         approximation_result_register <= {sar_trial[DATA_W-1:1],
            cmp_high};
   end

   // Read data; the result shows trial bits while sampling or converting, i.e. undefined
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (rd) begin
         if (hit_mode)
            rdata <= conversion_mode_register;
         else if (addr == RESULT_ADDR)
            rdata <= (state == SADC_SAMPLE || state == SADC_CONV) ?
                     sar_trial : approximation_result_register;
         else
            rdata <= '0;
      end
   end

   // Analog-side controls
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         channel_sel     <= '0;
         bias_select_bit <= 1'b0;
         sample_hold     <= 1'b0;
         dac_code        <= '0;
         busy            <= 1'b0;
      end else begin
         channel_sel     <= conversion_mode_register[CH_HI:CH_LO];
         bias_select_bit <= conversion_mode_register[BIAS_BIT];
         sample_hold     <= (state == SADC_SAMPLE);
         dac_code        <= sar_trial;
         busy            <= (state != SADC_IDLE);
      end
   end
endmodule
`default_nettype wire
